// File: rtl/tcs_regs.vh
/*
 Register offsets, field positions, reset values and timing counts for the
 transmitter control supervisor. Assumes a 10 MHz system clock and byte
 addresses on an 8-bit register port with 32-bit data.
*/
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

`define CLK_HZ 10000000
`define WD_TIMEOUT_MS 1000
`define WD_TIMEOUT_CYC (`CLK_HZ / 1000 * `WD_TIMEOUT_MS)
`define WD_PULSE_US 100
`define WD_PULSE_CYC (`CLK_HZ / 1000000 * `WD_PULSE_US)
`define POT_DIV_CYC 5

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONFIG 8'h08
`define ADDR_LED 8'h0C
`define ADDR_TEST 8'h10
`define ADDR_DOUT 8'h14
`define ADDR_DIN 8'h18
`define ADDR_ASEL 8'h1C
`define ADDR_DEC 8'h20
`define ADDR_POT 8'h24

`define CTRL_STROBE 0
`define CTRL_SYS_TX 1
`define CTRL_DATA_TX 2

`define ST_SELF_TEST 0
`define ST_OP_SEL 1
`define ST_POT_BUSY 2
`define ST_CTRL_RST 3

`define CFG_MOD 0
`define CFG_MUTE 1
`define CFG_NO_IFP 2
`define CFG_NO_MOD 3
`define CFG_NO_UPC 4
`define CFG_EXT_SCR 5
`define CFG_INV_ILK 6
`define CFG_EXT_EXC 7

`define LED_OFF 2'h0
`define LED_RED 2'h1
`define LED_GREEN 2'h2
`define LED_AMBER 2'h3

`define DEC_EN 3
`define DEC_DISP_WR 4
`define POT_DEV 16
`define POT_BITS 5'h10

`define RST_LED 8'h00
`define RST_DOUT 8'hFF
`define RST_TEST 8'hFF
`define RST_ASEL 4'h0

`endif

// File: rtl/strobe_watchdog.v
/*
 Strobe watchdog: pulses an expiry output when the strobe has not toggled
 within the timeout. Assumes strobe is synchronous to clock_i.
*/
`timescale 1ns/1ps
module strobe_watchdog #(
   parameter TIMEOUT_CYC = 10000000,
   parameter PULSE_CYC = 1000
) (
   input wire clock_i,
   input wire rst_b_i,
   input wire strobe_i,
   output reg expired_o
);
   reg strobe_reg;
   reg [23:0] idle_reg;
   reg [23:0] pulse_reg;
   wire toggled = strobe_i ^ strobe_reg;

   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strobe_reg <= 1'b0;
         idle_reg <= 24'h000000;
         pulse_reg <= 24'h000000;
         expired_o <= 1'b0;
      end else begin
         strobe_reg <= strobe_i;
         // any edge of the strobe restarts the one second window
         if (toggled || expired_o)
            idle_reg <= 24'h000000;
         else if (idle_reg == TIMEOUT_CYC[23:0] - 24'h000001) begin
            idle_reg <= 24'h000000;
            expired_o <= 1'b1;
            pulse_reg <= PULSE_CYC[23:0] - 24'h000001;
         end else
            idle_reg <= idle_reg + 24'h000001;
         if (expired_o) begin
            if (pulse_reg == 24'h000000)
               expired_o <= 1'b0;
            else
               pulse_reg <= pulse_reg - 24'h000001;
         end
      end
   end
endmodule

// File: rtl/transmitter_control_supervisor.v
/*
 Supervisory logic of the transmitter control board: watchdog reset,
 programming-line routing, self-test detection, serial fan-out, remote and
 auxiliary discrete I/O, configuration decode, front-panel indicator latch,
 serial potentiometer driver and analog/decoder selects.
 Assumes all inputs are synchronous to clock_i and that firmware uses the
 register port below.
*/
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "tcs_regs.vh"
module transmitter_control_supervisor #(
   parameter WD_TIMEOUT_CYC = `WD_TIMEOUT_CYC,
   parameter WD_PULSE_CYC = `WD_PULSE_CYC,
   parameter POT_DIV_CYC = `POT_DIV_CYC,
   parameter ASEL_W = 4
) (
   input wire clock_i,
   input wire rst_b_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire prog_reset_b_i,
   input wire prog_sck_i,
   input wire prog_mosi_i,
   output reg prog_miso_o,
   input wire ctrl_miso_i,
   output reg ctrl_sck_o,
   output reg ctrl_mosi_o,
   output reg ctrl_reset_b_o,
   output reg programming_indicator_o,
   input wire test_sense1_i,
   input wire test_sense2_i,
   output wire [7:0] test_result_indicators_b_o,
   input wire ctrl_sys_txd_i,
   output wire ctrl_sys_rxd_o,
   output reg sys_txd_o,
   output reg sys_tx_en_o,
   input wire sys_rxd_i,
   input wire ctrl_data_txd_i,
   output reg ctrl_data_rxd_o,
   input wire [2:0] data_rxd_i,
   output reg [2:0] data_txd_o,
   output reg data_tx_en_o,
   input wire operation_select_switch_i,
   input wire [3:0] amp_pwr_mon_i,
   input wire [3:0] exc_pwr_mon_i,
   output reg [3:0] sys_pwr_mon_o,
   output reg transmitter_mode_o,
   input wire [3:0] remote_in_i,
   output wire [3:0] remote_out_on_o,
   input wire [3:0] aux_i,
   output wire [3:0] aux_o,
   output wire [3:0] aux_oe_o,
   input wire [7:0] firmware_config_switch_i,
   output reg modulator_present_o,
   output reg interlock_mute_only_o,
   output reg if_proc_absent_o,
   output reg modulator_absent_o,
   output reg upconverter_absent_o,
   output reg extended_screens_o,
   output reg low_power_mute_en_o,
   output reg interlock_active_o,
   output wire [3:0] led_red_b_o,
   output wire [3:0] led_green_b_o,
   output reg pot_sdata_o,
   output reg pot_sclk_o,
   output reg [1:0] pot_en_b_o,
   output wire [ASEL_W-1:0] analog_sel_o,
   output reg [7:0] dec_sel_b_o,
   output reg display_write_o
);
   // one-hot states of the potentiometer shifter
   localparam [2:0] POT_IDLE = 3'b001;
   localparam [2:0] POT_SHIFT = 3'b010;
   localparam [2:0] POT_DONE = 3'b100;

   reg [2:0] ctrl_reg;
   reg [7:0] led_reg;
   reg [7:0] test_reg;
   reg [7:0] dout_reg;
   reg [ASEL_W-1:0] asel_reg;
   reg [4:0] dec_reg;
   reg [2:0] pot_state_reg;
   reg [2:0] pot_state_next;
   reg [15:0] pot_shift_reg;
   reg [4:0] pot_cnt_reg;
   reg [7:0] pot_div_reg;
   reg pot_dev_reg;
   reg [31:0] rd_next;
   wire wd_expired;
   wire in_reset;
   wire pot_tick;
   wire pot_start;
   wire self_test_start;
   wire [3:0] remote_logic;
   wire [3:0] aux_in_logic;

   // indicator control levels from a colour code, lines active low
   function [1:0] led_lines;
      input [1:0] code;
      begin
         led_lines[1] = ~(code == `LED_RED || code == `LED_AMBER);
         led_lines[0] = ~(code == `LED_GREEN || code == `LED_AMBER);
      end
   endfunction

   // one-hot active-low decode of a three-bit select
   function [7:0] dec_onehot_b;
      input [2:0] idx;
      input en;
      begin
         dec_onehot_b = ~({7'h00, en} << idx);
      end
   endfunction

   strobe_watchdog #(
      .TIMEOUT_CYC(WD_TIMEOUT_CYC),
      .PULSE_CYC(WD_PULSE_CYC)
   ) u_wd (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .strobe_i(ctrl_reg[`CTRL_STROBE]),
      .expired_o(wd_expired)
   );

   assign in_reset = ~prog_reset_b_i | wd_expired;
   assign self_test_start = ~test_sense1_i & test_sense2_i;
   assign remote_logic = ~remote_in_i;
   // an aux line only reads as input while its driver is off
   assign aux_in_logic = ~aux_i & ~aux_oe_o;
   assign ctrl_sys_rxd_o = sys_rxd_i;
   assign pot_start = wr_i && addr_i == `ADDR_POT && pot_state_reg == POT_IDLE;
   assign pot_tick = pot_div_reg == 8'h00;

   // register writes
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= 3'h0;
         led_reg <= `RST_LED;
         test_reg <= `RST_TEST;
         dout_reg <= `RST_DOUT;
         asel_reg <= `RST_ASEL;
         dec_reg <= 5'h00;
      end else if (wr_i) begin
         case (addr_i)
            `ADDR_CTRL: ctrl_reg <= wdata_i[2:0];
            `ADDR_LED: led_reg <= wdata_i[7:0];
            `ADDR_TEST: test_reg <= wdata_i[7:0];
            `ADDR_DOUT: dout_reg <= wdata_i[7:0];
            `ADDR_ASEL: asel_reg <= wdata_i[ASEL_W-1:0];
            `ADDR_DEC: dec_reg <= wdata_i[4:0];
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rd_next = 32'h00000000;
      case (addr_i)
         `ADDR_CTRL: rd_next[2:0] = ctrl_reg;
         `ADDR_STATUS: begin
            rd_next[`ST_SELF_TEST] = self_test_start;
            rd_next[`ST_OP_SEL] = operation_select_switch_i;
            rd_next[`ST_POT_BUSY] = pot_state_reg != POT_IDLE;
            rd_next[`ST_CTRL_RST] = in_reset;
         end
         `ADDR_CONFIG: rd_next[7:0] = firmware_config_switch_i;
         `ADDR_LED: rd_next[7:0] = led_reg;
         `ADDR_TEST: rd_next[7:0] = test_reg;
         `ADDR_DOUT: rd_next[7:0] = dout_reg;
         `ADDR_DIN: rd_next[7:0] = {aux_in_logic, remote_logic};
         `ADDR_ASEL: rd_next[ASEL_W-1:0] = asel_reg;
         `ADDR_DEC: rd_next[4:0] = dec_reg;
         `ADDR_POT: rd_next[15:0] = pot_shift_reg;
         default: rd_next = 32'h00000000;
      endcase
   end

   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i)
         rdata_o <= 32'h00000000;
      else if (rd_i)
         rdata_o <= rd_next;
      else
         rdata_o <= 32'h00000000;
   end

   // controller reset and programming-line routing
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reset_b_o <= 1'b0;
         programming_indicator_o <= 1'b0;
         ctrl_sck_o <= 1'b0;
         ctrl_mosi_o <= 1'b0;
         prog_miso_o <= 1'b0;
      end else begin
         ctrl_reset_b_o <= ~in_reset;
         programming_indicator_o <= in_reset;
         // switch closed only while the controller is held in reset
         ctrl_sck_o <= in_reset & prog_sck_i;
         ctrl_mosi_o <= in_reset & prog_mosi_i;
         prog_miso_o <= in_reset & ctrl_miso_i;
      end
   end

   // serial ports
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_txd_o <= 1'b1;
         sys_tx_en_o <= 1'b0;
         data_txd_o <= 3'h7;
         data_tx_en_o <= 1'b0;
         ctrl_data_rxd_o <= 1'b1;
      end else begin
         // the system bus is driven only while the CTRL_SYS_TX bit is set
         sys_txd_o <= ctrl_sys_txd_i;
         sys_tx_en_o <= ctrl_reg[`CTRL_SYS_TX];
         // data port drives only when firmware answers
         data_tx_en_o <= ctrl_reg[`CTRL_DATA_TX];
         data_txd_o <= {3{ctrl_data_txd_i}};
         // idle-high lines: a start bit on any channel passes
         ctrl_data_rxd_o <= &data_rxd_i;
      end
   end

   // operation select and configuration decode
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         transmitter_mode_o <= 1'b0;
         sys_pwr_mon_o <= 4'h0;
         modulator_present_o <= 1'b0;
         interlock_mute_only_o <= 1'b0;
         if_proc_absent_o <= 1'b0;
         modulator_absent_o <= 1'b0;
         upconverter_absent_o <= 1'b0;
         extended_screens_o <= 1'b0;
         low_power_mute_en_o <= 1'b1;
         interlock_active_o <= 1'b0;
      end else begin
         transmitter_mode_o <= operation_select_switch_i;
         sys_pwr_mon_o <= operation_select_switch_i ? amp_pwr_mon_i
            : exc_pwr_mon_i;
         modulator_present_o <= firmware_config_switch_i[`CFG_MOD];
         interlock_mute_only_o <= firmware_config_switch_i[`CFG_MUTE];
         // external exciter forces all three units absent
         if_proc_absent_o <= firmware_config_switch_i[`CFG_NO_IFP]
            | firmware_config_switch_i[`CFG_EXT_EXC];
         modulator_absent_o <= firmware_config_switch_i[`CFG_NO_MOD]
            | firmware_config_switch_i[`CFG_EXT_EXC];
         upconverter_absent_o <= firmware_config_switch_i[`CFG_NO_UPC]
            | firmware_config_switch_i[`CFG_EXT_EXC];
         extended_screens_o <= firmware_config_switch_i[`CFG_EXT_SCR];
         low_power_mute_en_o <= ~firmware_config_switch_i[`CFG_INV_ILK];
         interlock_active_o <= remote_logic[0]
            ^ firmware_config_switch_i[`CFG_INV_ILK];
      end
   end

   // discrete outputs: latch bit low turns the open-drain driver on
   assign remote_out_on_o = ~dout_reg[3:0];
   assign aux_oe_o = ~dout_reg[7:4];
   assign aux_o = 4'h0;
   assign test_result_indicators_b_o = test_reg;
   assign analog_sel_o = asel_reg;

   // indicator latch: four channels of red/green lines
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : led_ch
         wire [1:0] lines = led_lines(led_reg[2*g+1:2*g]);
         assign led_red_b_o[g] = lines[1];
         assign led_green_b_o[g] = lines[0];
      end
   endgenerate

   // decoder selects and display buffer direction
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dec_sel_b_o <= 8'hFF;
         display_write_o <= 1'b0;
      end else begin
         dec_sel_b_o <= dec_onehot_b(dec_reg[2:0], dec_reg[`DEC_EN]);
         display_write_o <= dec_reg[`DEC_DISP_WR];
      end
   end

   // serial potentiometer bit-rate divider
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i)
         pot_div_reg <= 8'h00;
      else if (pot_state_reg == POT_IDLE || pot_tick)
         pot_div_reg <= POT_DIV_CYC[7:0] - 8'h01;
      else
         pot_div_reg <= pot_div_reg - 8'h01;
   end

   always @* begin
      pot_state_next = pot_state_reg;
      case (pot_state_reg)
         POT_IDLE: if (pot_start) pot_state_next = POT_SHIFT;
         POT_SHIFT: if (pot_tick && pot_sclk_o && pot_cnt_reg == 5'h01)
            pot_state_next = POT_DONE;
         POT_DONE: if (pot_tick) pot_state_next = POT_IDLE;
         default: pot_state_next = POT_IDLE;
      endcase
   end

   // msb first; data changes on the falling clock, sampled on the rising
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pot_state_reg <= POT_IDLE;
         pot_shift_reg <= 16'h0000;
         pot_cnt_reg <= 5'h00;
         pot_dev_reg <= 1'b0;
         pot_sdata_o <= 1'b0;
         pot_sclk_o <= 1'b0;
         pot_en_b_o <= 2'h3;
      end else begin
         pot_state_reg <= pot_state_next;
         case (pot_state_reg)
            POT_IDLE: begin
               pot_sclk_o <= 1'b0;
               pot_en_b_o <= 2'h3;
               if (pot_start) begin
                  pot_shift_reg <= {wdata_i[14:0], 1'b0};
                  pot_sdata_o <= wdata_i[15];
                  pot_cnt_reg <= `POT_BITS;
                  pot_dev_reg <= wdata_i[`POT_DEV];
                  pot_en_b_o <= wdata_i[`POT_DEV] ? 2'h1 : 2'h2;
               end
            end
            POT_SHIFT: if (pot_tick) begin
               pot_sclk_o <= ~pot_sclk_o;
               if (pot_sclk_o) begin
                  pot_sdata_o <= pot_shift_reg[15];
                  pot_shift_reg <= {pot_shift_reg[14:0], 1'b0};
                  pot_cnt_reg <= pot_cnt_reg - 5'h01;
               end
            end
            POT_DONE: if (pot_tick) pot_en_b_o <= 2'h3;
            default: pot_en_b_o <= 2'h3;
         endcase
      end
   end
endmodule

// File: sim/tcs_checker_asserts.sv
/* Port assertions for the transmitter control supervisor.
   Assumes one clock and the shortened watchdog counts set by the bench. */
`timescale 1ns/1ps
`include "tcs_regs.vh"
module tcs_checker #(
   parameter WD_TIMEOUT_CYC = 200,
   parameter WD_PULSE_CYC = 4
) (
   input wire clock_i,
   input wire rst_b_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire prog_reset_b_i,
   input wire prog_sck_i,
   input wire prog_mosi_i,
   input wire ctrl_sck_o,
   input wire ctrl_mosi_o,
   input wire ctrl_reset_b_o,
   input wire programming_indicator_o,
   input wire ctrl_sys_txd_i,
   input wire sys_txd_o,
   input wire ctrl_data_txd_i,
   input wire [2:0] data_txd_o,
   input wire [2:0] data_rxd_i,
   input wire ctrl_data_rxd_o,
   input wire operation_select_switch_i,
   input wire [3:0] amp_pwr_mon_i,
   input wire [3:0] exc_pwr_mon_i,
   input wire [3:0] sys_pwr_mon_o,
   input wire [3:0] remote_in_i,
   input wire [7:0] firmware_config_switch_i,
   input wire if_proc_absent_o,
   input wire low_power_mute_en_o,
   input wire interlock_active_o
);
   reg strobe_seen;
   reg [15:0] idle_cnt;
   // cycles since firmware last changed the strobe bit
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strobe_seen <= 1'b0;
         idle_cnt <= 16'h0000;
      end else if (wr_i && addr_i == `ADDR_CTRL && wdata_i[0] != strobe_seen) begin
         strobe_seen <= wdata_i[0];
         idle_cnt <= 16'h0000;
      end else if (idle_cnt != 16'hFFFF) begin
         idle_cnt <= idle_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence bite_s;
      ##[1:12] !ctrl_reset_b_o;
   endsequence
   sequence pulse_s;
      !ctrl_reset_b_o[*4] ##1 ctrl_reset_b_o;
   endsequence
   a_wd_quiet: assert property (idle_cnt < WD_TIMEOUT_CYC - 4 && prog_reset_b_i
      && $past(prog_reset_b_i) && $past(ctrl_reset_b_o) |-> ctrl_reset_b_o)
      else $error("controller reset while strobe active");
   a_wd_bites: assert property (idle_cnt == WD_TIMEOUT_CYC - 4 |-> bite_s)
      else $error("watchdog did not reset controller");
   a_bite_len: assert property ($fell(ctrl_reset_b_o) && prog_reset_b_i
      && $past(prog_reset_b_i) |-> pulse_s)
      else $error("watchdog pulse length wrong");
   a_prog_holds: assert property (!prog_reset_b_i |=> !ctrl_reset_b_o
      && programming_indicator_o)
      else $error("programming reset not held");
   a_route_lines: assert property ($past(rst_b_i) && !$past(prog_reset_b_i)
      && !$past(prog_reset_b_i, 2) |-> ctrl_sck_o == $past(prog_sck_i)
      && ctrl_mosi_o == $past(prog_mosi_i))
      else $error("programming lines not routed");
   a_data_fanout: assert property ($past(rst_b_i) |->
      data_txd_o == {3{$past(ctrl_data_txd_i)}})
      else $error("data byte not sent on all channels");
   a_data_merge: assert property ($past(rst_b_i) |->
      ctrl_data_rxd_o == &$past(data_rxd_i))
      else $error("data receive merge wrong");
   a_sys_pass: assert property ($past(rst_b_i) |-> sys_txd_o == $past(ctrl_sys_txd_i))
      else $error("system bus transmit wrong");
   a_pwr_route: assert property ($past(rst_b_i) |-> sys_pwr_mon_o ==
      ($past(operation_select_switch_i) ? $past(amp_pwr_mon_i) : $past(exc_pwr_mon_i)))
      else $error("power monitor routing wrong");
   a_cfg_decode: assert property ($past(rst_b_i) |->
      if_proc_absent_o == ($past(firmware_config_switch_i[2]) | $past(firmware_config_switch_i[7]))
      && low_power_mute_en_o == !$past(firmware_config_switch_i[6])
      && interlock_active_o == (!$past(remote_in_i[0]) ^ $past(firmware_config_switch_i[6])))
      else $error("configuration decode wrong");
   a_rd_idle: assert property ($past(rst_b_i) && !$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not idle");
endmodule

bind transmitter_control_supervisor tcs_checker #(
   .WD_TIMEOUT_CYC(WD_TIMEOUT_CYC), .WD_PULSE_CYC(WD_PULSE_CYC)) u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .prog_reset_b_i(prog_reset_b_i), .prog_sck_i(prog_sck_i),
   .prog_mosi_i(prog_mosi_i), .ctrl_sck_o(ctrl_sck_o), .ctrl_mosi_o(ctrl_mosi_o),
   .ctrl_reset_b_o(ctrl_reset_b_o), .programming_indicator_o(programming_indicator_o),
   .ctrl_sys_txd_i(ctrl_sys_txd_i), .sys_txd_o(sys_txd_o), .ctrl_data_txd_i(ctrl_data_txd_i),
   .data_txd_o(data_txd_o), .data_rxd_i(data_rxd_i), .ctrl_data_rxd_o(ctrl_data_rxd_o),
   .operation_select_switch_i(operation_select_switch_i), .amp_pwr_mon_i(amp_pwr_mon_i),
   .exc_pwr_mon_i(exc_pwr_mon_i), .sys_pwr_mon_o(sys_pwr_mon_o), .remote_in_i(remote_in_i),
   .firmware_config_switch_i(firmware_config_switch_i), .if_proc_absent_o(if_proc_absent_o),
   .low_power_mute_en_o(low_power_mute_en_o), .interlock_active_o(interlock_active_o));

// File: sim/serial_far_end.sv
/* Far side of the serial links: system bus slaves and three data channels.
   Assumes idle receive lines sit high through their pull-ups. */
`timescale 1ns/1ps
module serial_far_end (
   input wire sys_txd_i,
   input wire sys_tx_en_i,
   input wire [2:0] data_txd_i,
   input wire reply_i,
   input wire [1:0] chan_i,
   output wire sys_rxd_o,
   output wire [2:0] data_rxd_o,
   output wire [2:0] heard_o
);
   // slaves answer only once the master has released the bus
   assign sys_rxd_o = sys_tx_en_i ? sys_txd_i : reply_i;
   // reply on one channel, the others idle high
   assign data_rxd_o = ~({2'b00, ~reply_i} << chan_i);
   assign heard_o = data_txd_i;
endmodule

// File: sim/tb_transmitter_control_supervisor.sv
/* Self-checking bench for the transmitter control supervisor.
   Assumes the register map of tcs_regs.vh and shortened watchdog counts. */
`timescale 1ns/1ps
`include "tcs_regs.vh"
module tb_transmitter_control_supervisor;
   localparam WD_T = 200;
   localparam WD_P = 4;
   reg clock_i = 1'b0;
   reg rst_b_i = 1'b0;
   reg [7:0] addr_i = 8'h00;
   reg [31:0] wdata_i = 32'h0;
   reg wr_i = 1'b0, rd_i = 1'b0, far_bit = 1'b1, prev;
   reg prog_reset_b_i = 1'b1, prog_sck_i = 1'b0, prog_mosi_i = 1'b0, ctrl_miso_i = 1'b0;
   reg test_sense1_i = 1'b1, test_sense2_i = 1'b1, ctrl_sys_txd_i = 1'b1;
   reg ctrl_data_txd_i = 1'b1, operation_select_switch_i = 1'b0;
   reg [3:0] amp_pwr_mon_i = 4'hA, exc_pwr_mon_i = 4'h5, remote_in_i = 4'hF, aux_i = 4'hF;
   reg [7:0] firmware_config_switch_i = 8'h00;
   reg [1:0] far_chan = 2'h0;
   reg [31:0] e;
   reg [3:0] m;
   wire [31:0] rdata_o;
   wire prog_miso_o, ctrl_sck_o, ctrl_mosi_o, ctrl_reset_b_o, programming_indicator_o;
   wire ctrl_sys_rxd_o, sys_txd_o, sys_tx_en_o, sys_rxd_i, ctrl_data_rxd_o, data_tx_en_o;
   wire [2:0] data_rxd_i, data_txd_o, far_heard;
   wire [7:0] test_result_indicators_b_o, dec_sel_b_o;
   wire [3:0] sys_pwr_mon_o, remote_out_on_o, aux_o, aux_oe_o, analog_sel_o;
   wire [3:0] led_red_b_o, led_green_b_o;
   wire transmitter_mode_o, modulator_present_o, interlock_mute_only_o, if_proc_absent_o;
   wire modulator_absent_o, upconverter_absent_o, extended_screens_o, low_power_mute_en_o;
   wire interlock_active_o, pot_sdata_o, pot_sclk_o, display_write_o;
   wire [1:0] pot_en_b_o;
   wire [7:0] cfg_out = {modulator_present_o, interlock_mute_only_o, if_proc_absent_o,
      modulator_absent_o, upconverter_absent_o, extended_screens_o, low_power_mute_en_o,
      interlock_active_o};
   integer bad_count = 0, n_compared = 0, i, j, k;

   // every dut port meets the bench signal of its own name
   transmitter_control_supervisor #(.WD_TIMEOUT_CYC(WD_T), .WD_PULSE_CYC(WD_P),
      .POT_DIV_CYC(5), .ASEL_W(4)) dut (.*);

   serial_far_end far (.sys_txd_i(sys_txd_o), .sys_tx_en_i(sys_tx_en_o),
      .data_txd_i(data_txd_o), .reply_i(far_bit), .chan_i(far_chan), .sys_rxd_o(sys_rxd_i),
      .data_rxd_o(data_rxd_i), .heard_o(far_heard));

   always #50 clock_i = ~clock_i;

   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock_i);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock_i);
         wr_i <= 1'b1;
         addr_i <= a;
         wdata_i <= d;
         @(posedge clock_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp, input string what);
      begin
         @(posedge clock_i);
         rd_i <= 1'b1;
         addr_i <= a;
         @(posedge clock_i);
         rd_i <= 1'b0;
         #1;
         check(what, rdata_o, exp);
      end
   endtask
   task complete_run;
      begin
         $display("compared %0d mismatched %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      #500000;
      bad_count = bad_count + 1;
      $display("FAIL run time expected end seen hang");
      complete_run;
   end

   initial begin
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      tick(1);
      check("leds", {led_red_b_o, led_green_b_o}, 8'hFF);
      check("outs", {test_result_indicators_b_o, remote_out_on_o, aux_oe_o}, 16'hFF00);
      $display("reset values done");
      for (i = 0; i < 9; i = i + 1) begin
         e = (i < 8) ? (32'h1 << i) : 32'h0;
         @(posedge clock_i);
         firmware_config_switch_i <= e[7:0];
         remote_in_i <= {3'h7, i[0]};
         operation_select_switch_i <= i[0];
         tick(2);
         m = i[0] ? 4'hA : 4'h5;
         check("pwr", {transmitter_mode_o, sys_pwr_mon_o}, {i[0], m});
         check("cfg", cfg_out, {e[0], e[1], e[2] | e[7], e[3] | e[7], e[4] | e[7], e[5], ~e[6],
            ~i[0] ^ e[6]});
         rd(`ADDR_CONFIG, e, "cfg reg");
      end
      $display("configuration done");
      for (i = 0; i < 16; i = i + 1) begin
         wr(`ADDR_LED, i[1:0] << (2 * i[3:2]));
         tick(1);
         m = ~(4'h1 << i[3:2]);
         check("red", led_red_b_o, i[0] ? m : 4'hF);
         check("green", led_green_b_o, i[1] ? m : 4'hF);
      end
      $display("indicators done");
      wr(`ADDR_CTRL, 32'h6);
      for (i = 0; i < 3; i = i + 1) begin
         @(posedge clock_i);
         far_chan <= i[1:0];
         far_bit <= 1'b0;
         ctrl_data_txd_i <= i[0];
         ctrl_sys_txd_i <= i[0];
         tick(2);
         check("data", {ctrl_data_rxd_o, far_heard}, {1'b0, {3{i[0]}}});
         check("sys", {sys_tx_en_o, data_tx_en_o, ctrl_sys_rxd_o}, {2'h3, i[0]});
      end
      wr(`ADDR_CTRL, 32'h0);
      tick(2);
      check("sys idle", {sys_tx_en_o, data_tx_en_o, ctrl_sys_rxd_o}, 3'h0);
      $display("serial ports done");
      wr(`ADDR_CTRL, 32'h1);
      @(posedge clock_i);
      test_sense1_i <= 1'b0;
      operation_select_switch_i <= 1'b1;
      remote_in_i <= 4'h5;
      aux_i <= 4'h3;
      tick(8);
      rd(`ADDR_STATUS, 32'h3, "status");
      wr(`ADDR_DOUT, 32'hF0);
      tick(2);
      check("drv", {aux_oe_o, remote_out_on_o}, 8'h0F);
      rd(`ADDR_DIN, 32'hCA, "din");
      wr(`ADDR_DOUT, 32'h0F);
      tick(2);
      check("aux drv", {aux_oe_o, aux_o}, 8'hF0);
      rd(`ADDR_DIN, 32'h0A, "din drv");
      wr(`ADDR_TEST, 32'h5A);
      wr(`ADDR_ASEL, 32'h9);
      wr(`ADDR_DEC, 32'h1B);
      tick(2);
      check("test", test_result_indicators_b_o, 8'h5A);
      check("asel", analog_sel_o, 4'h9);
      check("dec", {display_write_o, dec_sel_b_o}, 9'h1F7);
      rd(8'h3C, 32'h0, "unmapped");
      $display("registers done");
      @(posedge clock_i);
      prog_reset_b_i <= 1'b0;
      prog_sck_i <= 1'b1;
      prog_mosi_i <= 1'b1;
      ctrl_miso_i <= 1'b1;
      tick(3);
      check("route", {ctrl_reset_b_o, programming_indicator_o, ctrl_sck_o, ctrl_mosi_o,
         prog_miso_o}, 5'h0F);
      rd(`ADDR_STATUS, 32'hB, "status rst");
      @(posedge clock_i);
      prog_reset_b_i <= 1'b1;
      tick(3);
      check("unroute", {ctrl_reset_b_o, programming_indicator_o, ctrl_sck_o, ctrl_mosi_o,
         prog_miso_o}, 5'h10);
      for (i = 0; i < 3; i = i + 1) begin
         wr(`ADDR_CTRL, {31'h0, i[0]});
         tick(WD_T - 20);
         check("no bite", ctrl_reset_b_o, 1'b1);
      end
      j = 0;
      while (ctrl_reset_b_o === 1'b1 && j < 400) begin
         tick(1);
         j = j + 1;
      end
      k = 0;
      while (ctrl_reset_b_o === 1'b0 && k < 50) begin
         tick(1);
         k = k + 1;
      end
      check("bite wait", (j >= 18 && j <= 30), 1'b1);
      check("bite len", k, WD_P);
      $display("watchdog done");
      wr(`ADDR_POT, 32'h1A5C3);
      e = 32'h0;
      j = 0;
      prev = 1'b0;
      for (i = 0; i < 400 && j < 16; i = i + 1) begin
         tick(1);
         if (pot_sclk_o === 1'b1 && !prev) begin
            e = {e[30:0], pot_sdata_o};
            j = j + 1;
         end
         prev = pot_sclk_o;
      end
      check("pot en", pot_en_b_o, 2'h1);
      check("pot bits", e, 32'hA5C3);
      k = 0;
      while (pot_en_b_o !== 2'h3 && k < 100) begin
         tick(1);
         k = k + 1;
      end
      check("pot end", pot_en_b_o, 2'h3);
      $display("potentiometer done");
      complete_run;
   end
endmodule
